// file: core/ptmr_period_timer.sv
// Top of the 8-bit period timer with APB registers
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ptmr_period_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptmr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irqOut
);
  import ptmr_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic rstMeta_ff; // Reset release stage one
  logic rstN; // Synchronised reset, active low
  logic rstSync_ff; // Reset release stage two
  logic [1:0] instDiv_ff; // Fosc/4 divider
  logic instTick_ff; // Instruction tick pulse
  logic [7:0] count_ff; // Timer count
  logic [7:0] period_ff; // Period
  logic [6:0] control_ff; // Control bits 6..0
  logic [0:0] status_ff; // Sticky match flag
  logic [0:0] mask_ff; // Interrupt mask
  logic irq_ff; // Interrupt output
  logic pready_ff; // Bus ready
  logic pslverr_ff; // Bus error
  logic [31:0] prdata_ff; // Read data
  logic [31:0] nxt_prdata; // Read mux
  logic nxt_pslverr; // Decode miss
  logic setup; // Setup phase
  logic wrDone; // Write completes
  logic wrCount; // Count write
  logic wrPeriod; // Period write
  logic wrControl; // Control write
  logic wrStatus; // Status write
  logic wrMask; // Mask write
  logic scalerClr; // Clears both scalers
  logic runEn; // Run enable
  logic preTick; // Prescaler output
  logic matchEvt; // Count met period
  logic postTick; // Postscaler output
  logic [3:0] preCnt; // Prescaler state
  logic [3:0] postCnt; // Postscaler state

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  // Two stages so release is clean on sys_clk
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  assign rstN = rstSync_ff;

  // ----------------------------------------
  // Instruction clock enable
  // ----------------------------------------
  // One pulse every fourth sys_clk edge
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      instDiv_ff <= 2'h0;
      instTick_ff <= 1'b0;
    end else begin
      instDiv_ff <= instDiv_ff + 2'h1;
      instTick_ff <= (instDiv_ff == INST_LAST);
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Setup phase loads read data and ready
  assign setup = psel & ~penable;
  // Write lands at the completing access edge
  assign wrDone = psel & penable & pwrite & pready_ff;
  assign wrCount = wrDone & (paddr == CNT_OFS);
  assign wrPeriod = wrDone & (paddr == PER_OFS);
  assign wrControl = wrDone & (paddr == CTL_OFS);
  assign wrStatus = wrDone & (paddr == STS_OFS);
  assign wrMask = wrDone & (paddr == MSK_OFS);

  // Read mux; unused bits read zero
  always_comb begin
    nxt_prdata = 32'h0;
    nxt_pslverr = 1'b0;
    unique case (paddr)
      CNT_OFS: begin
        nxt_prdata[7:0] = count_ff;
      end
      PER_OFS: begin
        nxt_prdata[7:0] = period_ff;
      end
      CTL_OFS: begin
        nxt_prdata[6:0] = control_ff; // Bit 7 reads 0
      end
      STS_OFS: begin
        nxt_prdata[0] = status_ff[0];
      end
      MSK_OFS: begin
        nxt_prdata[0] = mask_ff[0];
      end
      default: begin
        nxt_pslverr = 1'b1; // Unmapped address
      end
    endcase
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Ready for exactly one access cycle
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else if (setup) begin
      pready_ff <= 1'b1;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  chk_ready_after_setup: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    setup |=> pready_ff && pslverr_ff == $past(nxt_pslverr))
    else $error("no ready or wrong error after setup");

  chk_ready_one_cycle: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    !setup |=> !pready_ff && !pslverr_ff)
    else $error("ready or error stood outside the access cycle");

  chk_read_data_hold: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    !setup |=> $stable(prdata_ff))
    else $error("read data changed outside a setup cycle");

  // ----------------------------------------
  // Control, period and mask registers
  // ----------------------------------------
  // Control holds run bit and both selects
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      control_ff <= CTL_RST;
    end else if (wrControl) begin
      control_ff <= pwdata[6:0];
    end
  end
  chk_ctrl_write: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    wrControl |=> control_ff == $past(pwdata[6:0]))
    else $error("control write lost");
  // Period is plain read and write
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      period_ff <= PER_RST;
    end else if (wrPeriod) begin
      period_ff <= pwdata[7:0];
    end
  end
  // Mask gates the flag onto the interrupt
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      mask_ff <= MSK_RST;
    end else if (wrMask) begin
      mask_ff <= pwdata[0:0];
    end
  end

  // ----------------------------------------
  // Scaler control
  // ----------------------------------------
  // Count or control write restarts both scalers
  assign scalerClr = wrCount | wrControl;
  assign runEn = control_ff[CTL_RUN_BIT];

  // Prescaler on the instruction tick
  ptmr_prescaler uPre (
    .sysClk(sys_clk),
    .rstN(rstN),
    .instTick(instTick_ff),
    .runEn(runEn),
    .clrCnt(scalerClr),
    .preSel(control_ff[CTL_PRE_MSB:CTL_PRE_LSB]),
    .preTick(preTick),
    .preCnt(preCnt)
  );

  // Match happens on the wrapping increment
  assign matchEvt = preTick & (count_ff == period_ff);

  // Postscaler on period matches
  ptmr_postscaler uPost (
    .sysClk(sys_clk),
    .rstN(rstN),
    .matchEvt(matchEvt),
    .clrCnt(scalerClr),
    .postSel(control_ff[CTL_POST_MSB:CTL_POST_LSB]),
    .postTick(postTick),
    .postCnt(postCnt)
  );

  // ----------------------------------------
  // Count register
  // ----------------------------------------
  // Software write beats a prescaler pulse
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      count_ff <= CNT_RST;
    end else if (wrCount) begin
      count_ff <= pwdata[7:0];
    end else if (matchEvt) begin
      count_ff <= 8'h00;
    end else if (preTick) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Set beats a write-one clear in one cycle
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      status_ff <= STS_RST;
    end else if (postTick) begin
      status_ff[STS_MATCH_BIT] <= 1'b1;
    end else if (wrStatus && pwdata[STS_MATCH_BIT]) begin
      status_ff[STS_MATCH_BIT] <= 1'b0;
    end
  end
  // Level output while an unmasked flag stands
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end
  assign irqOut = irq_ff;

  chk_irq_follows: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    (status_ff & mask_ff) != 1'h0 |=> irq_ff)
    else $error("interrupt missing for unmasked flag");

  chk_irq_falls: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    (status_ff & mask_ff) == 1'h0 |=> !irq_ff)
    else $error("interrupt stood with no unmasked flag");

  chk_flag_clear: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    wrStatus && pwdata[STS_MATCH_BIT] && !postTick
    |=> !status_ff[STS_MATCH_BIT])
    else $error("write one did not clear the match flag");

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_inst_tick_rate: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    instTick_ff |=> !instTick_ff [*3] ##1 instTick_ff)
    else $error("instruction tick not every fourth cycle");

  chk_count_incr: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    preTick && !matchEvt && !wrCount
    |=> count_ff == $past(count_ff) + 8'h01)
    else $error("count did not advance on prescaler pulse");

  chk_count_wrap: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    preTick && (count_ff == period_ff) && !wrCount |=> count_ff == 8'h00)
    else $error("count did not wrap at period");

  chk_flag_set: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    postTick |=> status_ff[STS_MATCH_BIT] ##1 irq_ff == mask_ff[0])
    else $error("match flag or interrupt wrong after postscaler");

  chk_period_write: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    wrPeriod |=> period_ff == $past(pwdata[7:0]))
    else $error("period write lost");

  chk_count_write_clr: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    wrCount |=> preCnt == 4'h0 && postCnt == 4'h0
      && count_ff == $past(pwdata[7:0]))
    else $error("count write did not clear scalers");

  chk_ctrl_keeps_count: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    wrControl |=> $stable(count_ff) && preCnt == 4'h0 && postCnt == 4'h0)
    else $error("control write disturbed count or scalers");

  chk_stopped_hold: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    !runEn && !wrCount && !wrControl
    |-> !preTick && !postTick ##1 $stable(count_ff) && $stable(preCnt))
    else $error("stopped timer changed state");

  chk_tick_needs_run: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    preTick |-> runEn && !scalerClr)
    else $error("prescaler pulse while stopped or cleared");

  chk_post_restart: assert property (
    @(posedge sys_clk) disable iff (!rstN)
    postTick |=> postCnt == 4'h0)
    else $error("postscaler did not restart after its output");

endmodule // ptmr_period_timer
`default_nettype wire

// file: core/ptmr_pkg.sv
// Shared constants for the 8-bit period timer
`default_nettype none
package ptmr_pkg;
  // ----------------------------------------
  // Bus and register map
  // ----------------------------------------
  localparam int ADDR_W = 8; // APB address width
  localparam logic [7:0] CNT_OFS = 8'h00; // Count register
  localparam logic [7:0] PER_OFS = 8'h04; // Period register
  localparam logic [7:0] CTL_OFS = 8'h08; // Control register
  localparam logic [7:0] STS_OFS = 8'h0c; // Interrupt status
  localparam logic [7:0] MSK_OFS = 8'h10; // Interrupt mask
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CNT_RST = 8'h00; // Count after reset
  localparam logic [7:0] PER_RST = 8'hff; // Period after reset
  localparam logic [6:0] CTL_RST = 7'h00; // Control after reset
  localparam logic [0:0] STS_RST = 1'h0; // Status after reset
  localparam logic [0:0] MSK_RST = 1'h0; // Mask after reset
  // ----------------------------------------
  // Control field layout
  // ----------------------------------------
  localparam int CTL_PRE_LSB = 0; // Prescale select low bit
  localparam int CTL_PRE_MSB = 1; // Prescale select high bit
  localparam int CTL_RUN_BIT = 2; // Run enable
  localparam int CTL_POST_LSB = 3; // Postscale select low bit
  localparam int CTL_POST_MSB = 6; // Postscale select high bit
  localparam int STS_MATCH_BIT = 0; // Period match flag
  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam logic [1:0] INST_LAST = 2'h3; // Fosc/4 divider end
  localparam logic [1:0] PRE_SEL_DIV1 = 2'h0; // Code for 1:1
  localparam logic [1:0] PRE_SEL_DIV4 = 2'h1; // Code for 1:4
  localparam logic [3:0] PRE_LIM1 = 4'h0; // Last count, 1:1
  localparam logic [3:0] PRE_LIM4 = 4'h3; // Last count, 1:4
  localparam logic [3:0] PRE_LIM16 = 4'hf; // Last count, 1:16
endpackage
`default_nettype wire

// file: core/ptmr_postscaler.sv
// Postscaler counting period matches, 1:1 to 1:16
`timescale 1ns/1ns
`default_nettype none
module ptmr_postscaler (
  input wire logic sysClk,
  input wire logic rstN,
  input wire logic matchEvt,
  input wire logic clrCnt,
  input wire logic [3:0] postSel,
  output logic postTick,
  output logic [3:0] postCnt
);
  import ptmr_pkg::*;
  logic [3:0] postCnt_ff; // Matches seen so far
  // Output after select plus one matches
  assign postTick = matchEvt & ~clrCnt & (postCnt_ff >= postSel);
  assign postCnt = postCnt_ff;
  // Match counter; a clear wins
  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      postCnt_ff <= 4'h0;
    end else if (clrCnt) begin
      postCnt_ff <= 4'h0;
    end else if (postTick) begin
      postCnt_ff <= 4'h0;
    end else if (matchEvt) begin
      postCnt_ff <= postCnt_ff + 4'h1;
    end
  end
  chk_post_advance: assert property (@(posedge sysClk) disable iff (!rstN)
    matchEvt && !clrCnt && !postTick |=> postCnt_ff == $past(postCnt_ff) + 4'h1)
    else $error("postscaler did not advance on a match");
  chk_post_ratio: assert property (@(posedge sysClk) disable iff (!rstN)
    postTick |-> matchEvt && (postCnt_ff == postSel))
    else $error("postscaler output at wrong count");
endmodule // ptmr_postscaler
`default_nettype wire

// file: core/ptmr_prescaler.sv
// Prescaler dividing the instruction tick by 1, 4 or 16
`timescale 1ns/1ns
`default_nettype none
module ptmr_prescaler (
  input wire logic sysClk,
  input wire logic rstN,
  input wire logic instTick,
  input wire logic runEn,
  input wire logic clrCnt,
  input wire logic [1:0] preSel,
  output logic preTick,
  output logic [3:0] preCnt
);
  import ptmr_pkg::*;
  logic [3:0] preLim; // Last count for the chosen ratio
  logic [3:0] preCnt_ff; // Divider state
  // ----------------------------------------
  // Ratio decode
  // ----------------------------------------
  always_comb begin
    if (preSel == PRE_SEL_DIV1) begin
      preLim = PRE_LIM1;
    end else if (preSel == PRE_SEL_DIV4) begin
      preLim = PRE_LIM4;
    end else begin
      preLim = PRE_LIM16;
    end
  end
  // Tick only while running and not being cleared
  assign preTick = instTick & runEn & ~clrCnt & (preCnt_ff >= preLim);
  assign preCnt = preCnt_ff;
  // Counter; a clear wins over counting
  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      preCnt_ff <= 4'h0;
    end else if (clrCnt) begin
      preCnt_ff <= 4'h0;
    end else if (preTick) begin
      preCnt_ff <= 4'h0;
    end else if (instTick && runEn) begin
      preCnt_ff <= preCnt_ff + 4'h1;
    end
  end
  chk_pre_ratio: assert property (@(posedge sysClk) disable iff (!rstN)
    preTick |-> (preCnt_ff == preLim) && instTick)
    else $error("prescaler tick at wrong count");
endmodule // ptmr_prescaler
`default_nettype wire

// file: dv/ptmr_period_timer_tb_top.sv
// Self-checking bench for the 8-bit period timer over APB
`timescale 1ns/1ns
`default_nettype none
module ptmr_period_timer_tb_top;
  import ptmr_pkg::*;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  logic sysClk = 1'b0; // 10 MHz system clock
  logic rstN = 1'b0; // Active-low reset
  logic psel = 1'b0; // APB select
  logic penable = 1'b0; // APB enable
  logic pwrite = 1'b0; // APB direction
  logic [ADDR_W-1:0] paddr = '0; // APB address
  logic [31:0] pwdata = '0; // APB write data
  logic [31:0] prdata; // APB read data
  logic pready; // APB ready
  logic pslverr; // APB error
  logic irqOut; // Interrupt level
  logic [31:0] rdat; // Last read data
  logic rerr; // Last error response
  logic [31:0] rndState = 32'h00013bce; // Xorshift state
  int bad_count = 0; // Mismatches
  int n_tests = 0; // Comparisons
  int cyc = 0; // Clock edge counter
  logic [7:0] rstAddr [5] = '{CNT_OFS, PER_OFS, CTL_OFS, STS_OFS, MSK_OFS};
  logic [31:0] rstVal [5] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0};

  // Device under test
  ptmr_period_timer uut (
    .sys_clk(sysClk), .rst_n(rstN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irqOut(irqOut)
  );

  // Clock and edge counter
  always #50 sysClk = ~sysClk;
  always @(posedge sysClk) cyc <= cyc + 1;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Xorshift generator, fixed seed
  function logic [31:0] rnd();
    rndState = rndState ^ (rndState << 13);
    rndState = rndState ^ (rndState >> 17);
    rndState = rndState ^ (rndState << 5);
    return rndState;
  endfunction

  // Cycles between two flag events
  function int gapLen(input logic [1:0] pre, input logic [3:0] post,
                      input logic [7:0] per);
    int dv;
    dv = (pre == 2'h0) ? 1 : (pre == 2'h1) ? 4 : 16;
    return 4 * dv * (int'(per) + 1) * (int'(post) + 1);
  endfunction

  // Control word from its fields
  function logic [31:0] ctlVal(input logic [1:0] pre, input logic run,
                               input logic [3:0] post);
    return {25'h0, post, run, pre};
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // One APB transfer; returns after one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sysClk);
    penable <= 1'b1;
    do begin
      @(posedge sysClk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdat = prdata;
    rerr = pslverr;
    if (k >= 16) begin
      bad_count++;
      $display("BAD t=%0t no ready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sysClk);
  endtask

  // Wait for the interrupt level, bounded
  task automatic waitIrq(input logic lvl);
    int k;
    k = 0;
    while (irqOut !== lvl && k < 20000) begin
      @(posedge sysClk);
      k++;
    end
    if (k >= 20000) begin
      bad_count++;
      $display("BAD t=%0t interrupt wait timed out", $time);
    end
  endtask

  // Reset pulse, then register defaults
  task automatic doReset();
    rstN <= 1'b0;
    repeat (12) @(posedge sysClk);
    rstN <= 1'b1;
    repeat (3) @(posedge sysClk);
    chk(irqOut, 0, "irq after reset");
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, rstAddr[i], 32'h0);
      chk(rdat, rstVal[i], "reset value");
    end
  endtask

  // Program a rate, check first event and spacing
  task automatic runGap(input logic [1:0] pre, input logic [3:0] post,
                        input logic [7:0] per);
    int g, t0, t1, lo;
    g = gapLen(pre, post, per);
    lo = g - g / ((int'(per) + 1) * (int'(post) + 1)) - 8;
    apb(1'b1, CTL_OFS, 32'h0);
    apb(1'b1, PER_OFS, {24'h0, per});
    apb(1'b1, CNT_OFS, 32'h0);
    apb(1'b1, STS_OFS, 32'h1);
    apb(1'b1, MSK_OFS, 32'h1);
    apb(1'b1, CTL_OFS, ctlVal(pre, 1'b1, post));
    t0 = cyc;
    waitIrq(1'b1);
    t1 = cyc;
    chk(t1 - t0 >= lo && t1 - t0 <= g + 8, 1, "first event");
    apb(1'b1, STS_OFS, 32'h1);
    waitIrq(1'b0);
    waitIrq(1'b1);
    chk(cyc - t1, g, "event spacing");
  endtask

  // Verdict and end of run
  task stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    logic [7:0] cnt;
    int t0, t1;
    doReset();
    // Unmapped place: error, no data
    apb(1'b0, 8'h14, 32'h0);
    chk(rerr, 1, "unmapped read err");
    chk(rdat, 0, "unmapped read data");
    apb(1'b1, 8'h14, 32'hffffffff);
    chk(rerr, 1, "unmapped write err");
    // Full-width access, upper bits dropped
    v = rnd();
    cnt = {1'b0, v[14:8]};
    apb(1'b1, PER_OFS, v);
    apb(1'b0, PER_OFS, 32'h0);
    chk(rdat, {24'h0, v[7:0]}, "period readback");
    apb(1'b1, PER_OFS, 32'hff);
    apb(1'b1, CNT_OFS, {24'h0, cnt});
    repeat (40) @(posedge sysClk);
    apb(1'b0, CNT_OFS, 32'h0);
    chk(rdat, {24'h0, cnt}, "stopped count");
    // Control write keeps count, top bit reads zero
    apb(1'b1, CTL_OFS, 32'h99);
    apb(1'b0, CTL_OFS, 32'h0);
    chk(rdat, 32'h19, "control readback");
    apb(1'b0, CNT_OFS, 32'h0);
    chk(rdat, {24'h0, cnt}, "count after control write");
    // Run 1:1 for a while, then stop
    apb(1'b1, CTL_OFS, 32'h04);
    t0 = cyc;
    repeat (40) @(posedge sysClk);
    apb(1'b1, CTL_OFS, 32'h0);
    t1 = cyc;
    apb(1'b0, CNT_OFS, 32'h0);
    v = rdat - cnt;
    chk(v + 1 >= (t1 - t0) / 4 && v <= (t1 - t0) / 4 + 1, 1, "run");
    repeat (20) @(posedge sysClk);
    apb(1'b0, CNT_OFS, 32'h0);
    chk(rdat - cnt, v, "held after stop");
    // Every prescale code, random postscale and period
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      runGap((i < 4) ? 2'(i) : v[1:0], (i == 5) ? 4'hf : {1'b0, v[4:2]},
             8'(5 + v[6:5]));
    end
    // Mask hides the flag; write one clears it
    apb(1'b1, CTL_OFS, 32'h0);
    apb(1'b1, MSK_OFS, 32'h0);
    repeat (2) @(posedge sysClk);
    chk(irqOut, 0, "masked irq");
    apb(1'b0, STS_OFS, 32'h0);
    chk(rdat, 1, "flag kept");
    apb(1'b1, STS_OFS, 32'h1);
    apb(1'b0, STS_OFS, 32'h0);
    chk(rdat, 0, "flag cleared");
    // Second reset in mid-run
    apb(1'b1, PER_OFS, 32'h31);
    apb(1'b1, CTL_OFS, 32'h04);
    repeat (30) @(posedge sysClk);
    doReset();
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    // Longest rate sweep takes about 50000 cycles
    repeat (80000) @(posedge sysClk);
    bad_count++;
    $display("BAD t=%0t watchdog expired", $time);
    stop_test();
  end
endmodule // ptmr_period_timer_tb_top
`default_nettype wire
